// ---- src/sbsc_pkg.sv ----
// constants and types shared by the synchronous burst sram control logic
package sbsc_pkg;
    localparam int ADDR_W  = 18;
    localparam int HI_W    = 16;
    localparam int DATA_W  = 16;
    localparam int LANES   = 2;
    localparam int LANE_W  = 8;
    localparam int WORD_W  = 9;
    localparam int DEPTH   = 262144;
    localparam int CNT_W   = 2;

    localparam logic [CNT_W-1:0] CNT_RST   = 2'h0;
    localparam logic [CNT_W-1:0] CNT_STEP  = 2'h1;
    localparam logic             ORDER_RST = 1'b1;   // interleaved, as the strap pull-up gives
    localparam logic             OE_RST    = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_BURST = 2'b10
    } sbsc_state_t;
endpackage

// ---- src/sbsc_top.sv ----
// synchronous pipelined burst sram: strobes, chip selects, burst counter, byte-lane array
// Operation
// - controller strobe low at an edge loads the whole address bus.
// - any address capture also clears the burst counter and loads address bits 1:0 as the burst base.
// - with both strobes low and the primary select low the processor strobe acts, the controller strobe is dropped.
// - processor strobe is ignored while the primary chip select is high.
// - upper address sampled only when all three selects active and a strobe low.
// - lane 0 governs data 7:0 and parity 0, lane 1 data 15:8 and parity 1.
// - advance low steps the burst counter in the strap-chosen order.
// - global write low writes both lanes, overriding any byte write.
// - all synchronous inputs are captured on the rising clock edge.
// - primary select is active low; selected only when all three selects active.
// - second chip select is active high, sampled on the rising edge.
// - third chip select is active low, sampled on the rising edge.
// - burst-order strap high gives interleaved order, low gives linear.
// - data and parity outputs float whenever a write cycle is detected.
`timescale 1ns/10ps
`default_nettype none

module sbsc_top (
    input  wire logic                          i_clk,
    input  wire logic                          i_srst,
    input  wire logic [sbsc_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic                          i_proc_addr_strobe_n,
    input  wire logic                          i_ctrl_addr_strobe_n,
    input  wire logic                          i_burst_advance_n,
    input  wire logic                          i_chip_select_primary_n,
    input  wire logic                          i_chip_select_high,
    input  wire logic                          i_chip_select_third_n,
    input  wire logic                          i_lane_write_enable_n,
    input  wire logic [sbsc_pkg::LANES-1:0]    i_lane_select_n,
    input  wire logic                          i_all_lane_write_n,
    input  wire logic                          i_output_enable_n,
    input  wire logic                          i_snooze,
    input  wire logic                          i_burst_order,
    input  wire logic [sbsc_pkg::DATA_W-1:0]   i_dq,
    input  wire logic [sbsc_pkg::LANES-1:0]    i_parity_io,
    output var  logic [sbsc_pkg::DATA_W-1:0]   o_dq,
    output var  logic [sbsc_pkg::LANES-1:0]    o_parity_io,
    output var  logic                          o_data_oe
);
    import sbsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // state
    sbsc_state_t         state_q;
    sbsc_state_t         state_d;
    logic [HI_W-1:0]     hi_q;
    logic [CNT_W-1:0]    base_q;
    logic [CNT_W-1:0]    cnt_q;
    logic                order_q;

    ////////////////////////////////////////////////////////////////////////////////
    // decode
    wire                 run;
    wire                 selected;
    wire                 proc_take;
    wire                 ctrl_take;
    wire                 strobe;
    wire                 load;
    wire                 in_burst;
    wire                 advance;
    wire [CNT_W-1:0]     low_lin;
    wire [CNT_W-1:0]     low_int;
    wire [CNT_W-1:0]     cur_low;
    wire [ADDR_W-1:0]    cur_addr;
    wire [ADDR_W-1:0]    wr_addr;
    wire                 write_req;
    wire                 write_en;
    wire [LANES-1:0]     lane_wr;
    wire                 rd_en;
    wire [WORD_W-1:0]    rd_lane [LANES];
    wire [DATA_W-1:0]    rd_dq;
    wire [LANES-1:0]     rd_dp;

    // snooze holds the array and ignores every other input except reset and the burst-order strap
    assign run       = !i_snooze;
    assign selected  = !i_chip_select_primary_n && i_chip_select_high
                       && !i_chip_select_third_n;
    assign proc_take = run && !i_proc_addr_strobe_n
                       && !i_chip_select_primary_n;
    assign ctrl_take = run && !i_ctrl_addr_strobe_n && !proc_take;
    assign strobe    = proc_take || ctrl_take;
    assign load      = strobe && selected;
    assign in_burst  = (state_q == ST_BURST);
    assign advance   = run && !strobe && in_burst && !i_burst_advance_n;

    // two-bit arithmetic keeps every burst inside its aligned group of four
    assign low_lin   = base_q + cnt_q;
    assign low_int   = base_q ^ cnt_q;
    assign cur_low   = order_q ? low_int : low_lin;
    assign cur_addr  = {hi_q, cur_low};

    assign write_req = run && (!i_all_lane_write_n
                       || (!i_lane_write_enable_n && (~i_lane_select_n != '0)));
    // a processor-strobe cycle is always a read start; writes follow it
    assign write_en  = write_req && ((ctrl_take && selected)
                       || (in_burst && !strobe));
    assign wr_addr   = ctrl_take ? i_addr : cur_addr;
    assign rd_en     = run && in_burst && !write_req;

    ////////////////////////////////////////////////////////////////////////////////
    // array, one bank per byte lane with its parity bit
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            logic [WORD_W-1:0] mem [DEPTH];

            assign lane_wr[g] = write_en && (!i_all_lane_write_n
                                || (!i_lane_write_enable_n && !i_lane_select_n[g]));

            always_ff @(posedge i_clk) begin
                if (lane_wr[g]) begin
                    mem[wr_addr] <= {i_parity_io[g], i_dq[g*LANE_W +: LANE_W]};
                end
            end

            assign rd_lane[g]               = mem[cur_addr];
            assign rd_dq[g*LANE_W +: LANE_W] = rd_lane[g][LANE_W-1:0];
            assign rd_dp[g]                  = rd_lane[g][LANE_W];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // address path and burst counter
    always_comb begin
        state_d = state_q;
        if (load) begin
            state_d = ST_BURST;
        end else if (strobe) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_q <= ST_IDLE;
            cnt_q   <= CNT_RST;
            order_q <= ORDER_RST;
        end else begin
            state_q <= state_d;
            order_q <= i_burst_order;
            if (load) begin
                cnt_q <= CNT_RST;
            end else if (advance) begin
                cnt_q <= cnt_q + CNT_STEP;
            end
        end
    end

    // address registers hold no control meaning, so they need no reset
    always_ff @(posedge i_clk) begin
        if (load) begin
            hi_q   <= i_addr[ADDR_W-1:CNT_W];
            base_q <= i_addr[CNT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output pipeline; the enable is sampled, so it lags the pin by one edge
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_data_oe <= OE_RST;
            o_dq      <= '0;
            o_parity_io <= '0;
        end else begin
            o_data_oe <= rd_en && !i_output_enable_n;
            if (rd_en) begin
                o_dq        <= rd_dq;
                o_parity_io <= rd_dp;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_addr_capture: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (ctrl_take && selected)
        |=> (hi_q == $past(i_addr[ADDR_W-1:CNT_W])) && (base_q == $past(i_addr[CNT_W-1:0]))
            && (cnt_q == CNT_RST) && (state_q == ST_BURST))
        else $error("controller strobe did not capture the address");

    a_proc_priority: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (run && !i_proc_addr_strobe_n && !i_chip_select_primary_n && !i_ctrl_addr_strobe_n)
        |-> (lane_wr == '0))
        else $error("controller strobe acted beside the processor strobe");

    a_cs1_gates_proc: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_chip_select_primary_n && i_ctrl_addr_strobe_n)
        |=> (state_q == $past(state_q)) && (hi_q == $past(hi_q)))
        else $error("processor strobe acted with primary select high");

    a_deselect: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (strobe && !(i_chip_select_high && !i_chip_select_third_n))
        |=> (state_q == ST_IDLE))
        else $error("strobe captured while a chip select was inactive");

    a_lane_map: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (write_en && i_all_lane_write_n && !i_lane_write_enable_n)
        |-> (lane_wr == ~i_lane_select_n))
        else $error("byte lane write mapped to the wrong lane");

    a_burst_step: assert property (
        @(posedge i_clk) disable iff (i_srst)
        advance ##1 advance ##1 advance ##1 advance
        |=> (cnt_q == $past(cnt_q, 4)))
        else $error("burst counter did not wrap after four steps");

    a_global_write: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (write_en && !i_all_lane_write_n) |-> (lane_wr == '1))
        else $error("global write did not write all lanes");

    a_order_strap: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (in_burst && order_q && (base_q == 2'h1) && (cnt_q == 2'h1))
        |-> (cur_low == 2'h0))
        else $error("interleaved order gave the wrong location");

    a_write_float: assert property (
        @(posedge i_clk) disable iff (i_srst)
        write_req |=> !o_data_oe)
        else $error("outputs driven after a write cycle");

    a_read_pipe: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (rd_en && !i_output_enable_n) |=> (o_data_oe && (o_dq == $past(rd_dq))))
        else $error("read data not presented one edge after sampling");

    a_proc_capture: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (proc_take && selected)
        |=> (hi_q == $past(i_addr[ADDR_W-1:CNT_W])) && (base_q == $past(i_addr[CNT_W-1:0]))
            && (cnt_q == CNT_RST) && (state_q == ST_BURST))
        else $error("processor strobe did not capture the address");

    a_ctrl_write: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (ctrl_take && selected && !i_all_lane_write_n)
        |-> (lane_wr == '1) && (wr_addr == i_addr))
        else $error("controller strobe write missed its new address");

    a_count_step: assert property (
        @(posedge i_clk) disable iff (i_srst)
        advance |=> (cnt_q == CNT_W'($past(cnt_q) + CNT_STEP)))
        else $error("advance did not step the burst counter");

    a_count_hold: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (!load && !advance) |=> (cnt_q == $past(cnt_q)))
        else $error("burst counter moved without advance or load");

    // a step of two flips only bit 1 in either order, so no carry leaves the group
    a_half_group: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (in_burst && (cnt_q == 2'h2)) |-> (cur_low == (base_q ^ 2'h2)))
        else $error("burst left its aligned group of four");

    a_linear_wrap: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (in_burst && !order_q && (base_q == 2'h3) && (cnt_q == 2'h1))
        |-> (cur_low == 2'h0))
        else $error("linear order did not wrap inside its group");

    a_deselect_write: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (strobe && !selected) |-> (lane_wr == '0))
        else $error("deselected strobe wrote the array");

    a_idle_write: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (!in_burst && !strobe) |-> (lane_wr == '0))
        else $error("write landed while the device was deselected");

    a_primary_off: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (strobe && i_chip_select_primary_n) |=> (state_q == ST_IDLE))
        else $error("strobe captured with the primary select high");

    a_addr_hold: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (in_burst && !load) |=> (hi_q == $past(hi_q)) && (base_q == $past(base_q)))
        else $error("address register changed without a capture");

    a_no_lane_write: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_all_lane_write_n && i_lane_write_enable_n) |-> (lane_wr == '0))
        else $error("array written with no write enable low");

    a_oe_follow: assert property (
        @(posedge i_clk) disable iff (i_srst)
        i_output_enable_n |=> !o_data_oe)
        else $error("outputs driven with output enable high");

    a_snooze_hold: assert property (
        @(posedge i_clk) disable iff (i_srst)
        i_snooze |-> (lane_wr == '0) && !load)
        else $error("snooze let a write or capture through");

endmodule

`default_nettype wire

// ---- bench/sbsc_host.sv ----
// host model driving the sram pins one cycle at a time
`timescale 1ns/10ps
`default_nettype none
module sbsc_host (
    input  wire logic        i_clk,
    output var  logic [9:0]  o_ctl,
    output var  logic [17:0] o_addr,
    output var  logic [17:0] o_data
);
    initial begin
        o_ctl  = 10'h35f;
        o_addr = 18'h0;
        o_data = 18'h0;
    end
    // idle data lines flip each cycle so a stale value never reads as valid
    task automatic put(input logic [9:0] c, input logic [17:0] a, input logic [17:0] d);
        @(posedge i_clk);
        o_ctl  <= c;
        o_addr <= a;
        if (!c[3] || (!c[2] && c[1:0] != 2'h3))
            o_data <= d;
        else
            o_data <= ~o_data;
    endtask
endmodule
`default_nettype wire

// ---- bench/sbsc_top_tb.sv ----
// self-checking bench of the burst sram control logic
`timescale 1ns/10ps
`default_nettype none
module sbsc_top_tb;
    import sbsc_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, order = 1'b1, oe_n = 1'b0, snooze = 1'b0;
    logic [31:0] rs = 32'h9f79;
    int          error_cnt = 0, n_tests = 0;
    logic [17:0] a, s, d, mem [logic [17:0]];
    logic [9:0]  sel [3] = '{10'h2d7, 10'h217, 10'h277};
    wire logic [9:0]  ctl;
    wire logic [17:0] ha, hd;
    wire logic [15:0] rdq;
    wire logic [1:0]  rpar;
    wire logic        oe;
    initial forever #4 clk = ~clk;
    sbsc_host i_sbsc_host (.i_clk(clk), .o_ctl(ctl), .o_addr(ha), .o_data(hd));
    sbsc_top i_sbsc_top (
        .i_clk(clk), .i_srst(srst), .i_addr(ha),
        .i_proc_addr_strobe_n(ctl[9]), .i_ctrl_addr_strobe_n(ctl[8]),
        .i_chip_select_primary_n(ctl[7]), .i_chip_select_high(ctl[6]),
        .i_chip_select_third_n(ctl[5]), .i_burst_advance_n(ctl[4]),
        .i_all_lane_write_n(ctl[3]), .i_lane_write_enable_n(ctl[2]),
        .i_lane_select_n(ctl[1:0]), .i_output_enable_n(oe_n), .i_snooze(snooze),
        .i_burst_order(order), .i_dq(hd[15:0]), .i_parity_io(hd[17:16]),
        .o_dq(rdq), .o_parity_io(rpar), .o_data_oe(oe));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    function automatic logic [17:0] nxt(logic [17:0] b, logic [1:0] k, logic o);
        return {b[17:2], o ? b[1:0] ^ k : b[1:0] + k};
    endfunction
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp, input string m);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic rd_chk(input logic [17:0] ad, input logic eo = 1'b1);
        i_sbsc_host.put(10'h25f, ad, 18'h0);
        i_sbsc_host.put(10'h35f, 18'h0, 18'h0);
        i_sbsc_host.put(10'h35f, 18'h0, 18'h0);
        @(negedge clk);
        chk({rpar, rdq}, mem[ad], "read data");
        chk({17'h0, oe}, {17'h0, eo}, "read enable");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100us;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk({rpar, rdq}, 18'h0, "reset data");
        chk({17'h0, oe}, 18'h0, "reset enable");
        repeat (6) begin
            a = 18'(rnd());
            d = 18'(rnd());
            i_sbsc_host.put(10'h257, a, d);
            mem[a] = d;
            rd_chk(a);
        end
        for (int i = 0; i < 2; i++) begin
            a = 18'(rnd());
            d = 18'(rnd());
            s = 18'(rnd());
            i_sbsc_host.put(10'h257, a, d);
            // second edge: lane 0 only, then global write with the same lane selects
            i_sbsc_host.put(i ? 10'h352 : 10'h35a, 18'h0, s);
            mem[a] = i ? s : {d[17], s[16], d[15:8], s[7:0]};
            rd_chk(a);
        end
        for (int o = 0; o < 2; o++) begin
            @(posedge clk);
            order <= o[0];
            a = 18'(rnd()) & 18'h3fffc;
            for (int k = 0; k < 4; k++) begin
                d = 18'(rnd());
                i_sbsc_host.put(10'h257, a | 18'(k), d);
                mem[a | 18'(k)] = d;
            end
            // corner starts: linear from the top of the group forces the wrap
            s = a | (o[0] ? 18'h1 : 18'h3);
            i_sbsc_host.put(10'h25f, s, 18'h0);
            i_sbsc_host.put(10'h34f, 18'h0, 18'h0);
            for (int k = 0; k < 5; k++) begin
                i_sbsc_host.put(10'h34f, 18'h0, 18'h0);
                @(negedge clk);
                chk({rpar, rdq}, mem[nxt(s, 2'(k), o[0])], "burst data");
            end
        end
        i_sbsc_host.put(10'h057, s, ~mem[s]);
        rd_chk(s);
        foreach (sel[i]) begin
            i_sbsc_host.put(sel[i], s, ~mem[s]);
            rd_chk(s);
        end
        i_sbsc_host.put(10'h25f, s, 18'h0);
        i_sbsc_host.put(10'h34f, 18'h0, 18'h0);
        d = ~mem[nxt(s, 2'h1, order)];
        i_sbsc_host.put(10'h1df, 18'(rnd()), 18'h0);
        i_sbsc_host.put(10'h357, 18'h0, d);
        @(negedge clk);
        chk({rpar, rdq}, mem[nxt(s, 2'h1, order)], "gated strobe");
        i_sbsc_host.put(10'h35f, 18'h0, 18'h0);
        @(negedge clk);
        chk({17'h0, oe}, 18'h0, "write enable off");
        mem[nxt(s, 2'h1, order)] = d;
        rd_chk(nxt(s, 2'h1, order));
        // output enable high: data still registered, pins stay released
        @(posedge clk);
        oe_n <= 1'b1;
        rd_chk(s, 1'b0);
        @(posedge clk);
        oe_n <= 1'b0;
        // snooze over a write edge must leave the array untouched
        @(posedge clk);
        snooze <= 1'b1;
        i_sbsc_host.put(10'h257, s, ~mem[s]);
        i_sbsc_host.put(10'h35f, 18'h0, 18'h0);
        snooze <= 1'b0;
        rd_chk(s);
        end_sim();
    end
endmodule
`default_nettype wire
